// File: src/sar_adc_map.vh
// Register map, field positions, reset values and timing counts of the 8-bit SAR sequencer
`ifndef SAR_ADC_MAP_VH
`define SAR_ADC_MAP_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_INPUT_PAIR_CONFIG 8'hBA
`define ADDR_CHANNEL_SELECT 8'hBB
`define ADDR_CONVERTER_CONFIG 8'hBC
`define ADDR_DATA_WORD 8'hBE
`define ADDR_CONVERTER_CONTROL 8'hE8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_PAIR_CONFIG 4'h0
`define RST_CHANNEL 3'h0
`define RST_DIVIDER 5'h1F
`define RST_GAIN 2'h0
`define RST_DATA 8'h00

// ----------------------------------------
// Control register bit positions
// ----------------------------------------
`define CTL_ENABLE 7
`define CTL_TRACK_MODE 6
`define CTL_DONE 5
`define CTL_BUSY 4
`define CTL_SRC_HI 3
`define CTL_SRC_LO 1
`define CTL_WINDOW 0

// ----------------------------------------
// Config register fields
// ----------------------------------------
`define CFG_DIV_HI 7
`define CFG_DIV_LO 3
`define CFG_GAIN_HI 1
`define CFG_GAIN_LO 0

// ----------------------------------------
// Start source codes
// ----------------------------------------
`define SRC_BUSY_WRITE 3'h0
`define SRC_TIMER3 3'h1
`define SRC_EXT_START 3'h2
`define SRC_TIMER2 3'h3

// ----------------------------------------
// Gain codes
// ----------------------------------------
`define GAIN_HALF 2'h0
`define GAIN_ONE 2'h1
`define GAIN_TWO 2'h2
`define GAIN_FOUR 2'h3

// ----------------------------------------
// Timing in SAR clocks
// ----------------------------------------
`define TRACK_SAR_CLKS 4'h3
`define CONV_SAR_CLKS 4'hC

`endif

// File: src/sar_adc_sequencer_8bit.v
// Digital control of the 8-bit successive-approximation converter subsystem
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_map.vh"

// Overview of operation
// - Analog power, track-and-hold and gain stage on only while enable bit is 1.
// - SAR clock equals system clock divided by divider field plus one, 0 to 31.
// - Conversions start from one of five sources chosen by start source select.
// - Second external start used if enabled, else first external start triggers both.
// - Busy bit is 1 during the whole conversion, 0 once it completes.
// - Busy falling at conversion end sets done flag and requests interrupt when enabled.
// - Track mode 0 tracks continuously except while converting.
// - Track mode 1 tracks 3 SAR clocks after each start, then converts.
// - Low-power external mode tracks while start pin low, converts on its rise.
// - Gains 0.5, 1, 2 and 4 selectable; gain is 0.5 after reset.
// - Eight input channels selected by the channel select register.
// - Each pair bit makes its two inputs single-ended or a differential pair.
// - Upper four pair configuration bits read 0000b and ignore writes.
// - Result is an 8-bit word, two's complement for differential channels.
// - Pins with input mode bit 0 are analog and skipped by the crossbar.
// - Source codes: 000 busy, 001 timer3, 010 external, 011 timer2, 1xx primary.
// - Writing busy 1 starts only with source 000; writing busy 0 does nothing.
// - Gain codes 00, 01, 10, 11 give 0.5, 1, 2, 4.

module sar_adc_sequencer_8bit (
    input wire clk_sys,
    input wire resetn,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output wire [7:0] sfr_rdata,
    input wire timer3_overflow,
    input wire timer2_overflow,
    input wire primary_busy_write,
    input wire ext_convert_start_a,
    input wire ext_convert_start_b,
    input wire ext_start_a_in_crossbar,
    input wire ext_start_b_in_crossbar,
    input wire [7:0] port_input_mode_reg,
    input wire [7:0] conv_result_in,
    input wire irq_enable,
    output wire [7:0] crossbar_skip,
    output wire converter_power_on,
    output wire track_enable,
    output wire convert_active,
    output wire sar_clock_tick,
    output wire [1:0] gain_select,
    output wire [2:0] channel_select,
    output wire channel_is_diff,
    output wire conversion_irq
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_TRACK = 3'b010;
    localparam [2:0] ST_CONV = 3'b100;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [3:0] pair_cfg_ff;
    reg [2:0] channel_ff;
    reg [4:0] divider_ff;
    reg [1:0] gain_ff;
    reg enable_ff;
    reg track_mode_ff;
    reg done_ff;
    reg window_ff;
    reg [2:0] src_ff;
    reg [7:0] data_ff;
    reg [7:0] rdata_ff;
    reg [2:0] state_ff;
    reg [4:0] div_cnt_ff;
    reg tick_ff;
    reg [3:0] sar_cnt_ff;
    reg irq_ff;
    reg [1:0] sync_a_ff;
    reg [1:0] sync_b_ff;
    reg ext_prev_ff;

    reg [2:0] nxt_state;
    reg [3:0] nxt_sar_cnt;
    reg start_trig;
    reg [7:0] rd_mux;

    wire wr_ctl = sfr_wr && (sfr_addr == `ADDR_CONVERTER_CONTROL);
    // Gated by enable: a shutdown drops busy at once and can never set done
    wire busy = (state_ff == ST_CONV) && enable_ff;
    wire conv_finish = busy && tick_ff && (sar_cnt_ff == `CONV_SAR_CLKS - 4'h1);
    wire [7:0] ctl_value = {enable_ff, track_mode_ff, done_ff, busy, src_ff, window_ff};
    // Second input wins; first input alone serves both converters
    wire ext_level = ext_start_b_in_crossbar ? sync_b_ff[1] :
                     (ext_start_a_in_crossbar & sync_a_ff[1]);
    wire ext_rise = ext_level & ~ext_prev_ff;

    // ----------------------------------------
    // External start synchronisers
    // ----------------------------------------
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync_a_ff <= 2'h0;
            sync_b_ff <= 2'h0;
            ext_prev_ff <= 1'b0;
        end else begin
            sync_a_ff <= {sync_a_ff[0], ext_convert_start_a};
            sync_b_ff <= {sync_b_ff[0], ext_convert_start_b};
            ext_prev_ff <= ext_level;
        end
    end

    // ----------------------------------------
    // Start source selection
    // ----------------------------------------
    always @* begin
        start_trig = 1'b0;
        if (src_ff[2]) begin
            start_trig = primary_busy_write;
        end else begin
            case (src_ff)
                `SRC_BUSY_WRITE: start_trig = wr_ctl && sfr_wdata[`CTL_BUSY];
                `SRC_TIMER3: start_trig = timer3_overflow;
                `SRC_EXT_START: start_trig = ext_rise;
                `SRC_TIMER2: start_trig = timer2_overflow;
                default: start_trig = 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // SAR clock divider
    // ----------------------------------------
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_cnt_ff <= 5'h00;
            tick_ff <= 1'b0;
        end else if (!enable_ff) begin
            div_cnt_ff <= 5'h00;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (div_cnt_ff == divider_ff);
            div_cnt_ff <= (div_cnt_ff >= divider_ff) ? 5'h00 : div_cnt_ff + 5'h01;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @* begin
        nxt_state = state_ff;
        nxt_sar_cnt = sar_cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                // Ext start in low-power mode has already tracked while low
                if (enable_ff && start_trig) begin
                    nxt_sar_cnt = 4'h0;
                    if (track_mode_ff && (src_ff != `SRC_EXT_START)) begin
                        nxt_state = ST_TRACK;
                    end else begin
                        nxt_state = ST_CONV;
                    end
                end
            end
            ST_TRACK: begin
                if (tick_ff) begin
                    nxt_sar_cnt = sar_cnt_ff + 4'h1;
                    if (sar_cnt_ff == `TRACK_SAR_CLKS - 4'h1) begin
                        nxt_state = ST_CONV;
                        nxt_sar_cnt = 4'h0;
                    end
                end
            end
            ST_CONV: begin
                // New triggers are not looked at here
                if (tick_ff) begin
                    nxt_sar_cnt = sar_cnt_ff + 4'h1;
                end
                if (conv_finish) begin
                    nxt_state = ST_IDLE;
                    nxt_sar_cnt = 4'h0;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_sar_cnt = 4'h0;
            end
        endcase
        // Disabling abandons a conversion; the analog side is already off
        if (!enable_ff) begin
            nxt_state = ST_IDLE;
            nxt_sar_cnt = 4'h0;
        end
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
            sar_cnt_ff <= 4'h0;
            irq_ff <= 1'b0;
            data_ff <= `RST_DATA;
        end else begin
            state_ff <= nxt_state;
            sar_cnt_ff <= nxt_sar_cnt;
            irq_ff <= conv_finish && irq_enable;
            if (conv_finish) begin
                data_ff <= conv_result_in;
            end
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pair_cfg_ff <= `RST_PAIR_CONFIG;
            channel_ff <= `RST_CHANNEL;
            divider_ff <= `RST_DIVIDER;
            gain_ff <= `RST_GAIN;
            enable_ff <= 1'b0;
            track_mode_ff <= 1'b0;
            done_ff <= 1'b0;
            window_ff <= 1'b0;
            src_ff <= `SRC_BUSY_WRITE;
        end else begin
            if (sfr_wr && (sfr_addr == `ADDR_INPUT_PAIR_CONFIG)) begin
                pair_cfg_ff <= sfr_wdata[3:0];
            end
            if (sfr_wr && (sfr_addr == `ADDR_CHANNEL_SELECT)) begin
                channel_ff <= sfr_wdata[2:0];
            end
            if (sfr_wr && (sfr_addr == `ADDR_CONVERTER_CONFIG)) begin
                divider_ff <= sfr_wdata[`CFG_DIV_HI:`CFG_DIV_LO];
                gain_ff <= sfr_wdata[`CFG_GAIN_HI:`CFG_GAIN_LO];
            end
            if (wr_ctl) begin
                enable_ff <= sfr_wdata[`CTL_ENABLE];
                track_mode_ff <= sfr_wdata[`CTL_TRACK_MODE];
                window_ff <= sfr_wdata[`CTL_WINDOW];
                src_ff <= sfr_wdata[`CTL_SRC_HI:`CTL_SRC_LO];
            end
            // Hardware set beats a software clear in the same cycle
            if (conv_finish) begin
                done_ff <= 1'b1;
            end else if (wr_ctl) begin
                done_ff <= sfr_wdata[`CTL_DONE];
            end
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    always @* begin
        if (sfr_addr == `ADDR_INPUT_PAIR_CONFIG) begin
            rd_mux = {4'h0, pair_cfg_ff};
        end else if (sfr_addr == `ADDR_CHANNEL_SELECT) begin
            rd_mux = {5'h00, channel_ff};
        end else if (sfr_addr == `ADDR_CONVERTER_CONFIG) begin
            rd_mux = {divider_ff, 1'b0, gain_ff};
        end else if (sfr_addr == `ADDR_DATA_WORD) begin
            rd_mux = data_ff;
        end else if (sfr_addr == `ADDR_CONVERTER_CONTROL) begin
            rd_mux = ctl_value;
        end else begin
            rd_mux = 8'h00;
        end
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= 8'h00;
        end else if (sfr_rd) begin
            rdata_ff <= rd_mux;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    wire lp_ext_track = track_mode_ff && (src_ff == `SRC_EXT_START) && !ext_level;

    assign sfr_rdata = rdata_ff;
    assign converter_power_on = enable_ff;
    assign track_enable = enable_ff && (track_mode_ff ?
                          ((state_ff == ST_TRACK) || ((state_ff == ST_IDLE) && lp_ext_track)) :
                          !busy);
    assign convert_active = busy;
    assign sar_clock_tick = tick_ff;
    assign gain_select = gain_ff;
    assign channel_select = channel_ff;
    assign channel_is_diff = pair_cfg_ff[channel_ff[2:1]];
    assign crossbar_skip = ~port_input_mode_reg;
    assign conversion_irq = irq_ff;

endmodule // sar_adc_sequencer_8bit

`default_nettype wire

// File: testbench/sar_adc_sequencer_8bit_chk.sv
// Port assertions for the SAR sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_map.vh"
module sar_adc_sequencer_8bit_chk (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] port_input_mode_reg,
    input wire logic irq_enable,
    input wire logic [7:0] crossbar_skip,
    input wire logic converter_power_on,
    input wire logic track_enable,
    input wire logic convert_active,
    input wire logic sar_clock_tick,
    input wire logic [1:0] gain_select,
    input wire logic [2:0] channel_select,
    input wire logic conversion_irq
);
    logic [5:0] gap_ff;
    logic [4:0] cnt_ff;
    // ----------------------------------------
    // Tick spacing, ticks per conversion
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            gap_ff <= 6'h00;
            cnt_ff <= 5'h00;
        end else begin
            gap_ff <= (sar_clock_tick || !convert_active) ? 6'h00 : gap_ff + 6'h01;
            cnt_ff <= convert_active ? cnt_ff + {4'h0, sar_clock_tick} : 5'h00;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    AST_SKIP: assert property (crossbar_skip == ~port_input_mode_reg) else $error("skip");
    AST_IRQ_CAUSE: assert property (
        conversion_irq |-> $fell(convert_active) && $past(irq_enable))
        else $error("irq without end");
    AST_IRQ_DUE: assert property (
        $fell(convert_active) && converter_power_on && $past(irq_enable) |-> conversion_irq)
        else $error("irq missing");
    AST_IRQ_PULSE: assert property (conversion_irq |=> !conversion_irq) else $error("irq long");
    AST_OFF_IDLE: assert property (
        !converter_power_on |-> !convert_active && !track_enable)
        else $error("active while off");
    AST_START_EN: assert property (
        $rose(convert_active) |-> $past(converter_power_on))
        else $error("start while off");
    AST_TICK_GAP: assert property (gap_ff < 6'h20) else $error("tick gap");
    AST_CONV_LEN: assert property (cnt_ff <= {1'b0, `CONV_SAR_CLKS}) else $error("conv long");
    AST_GAIN_WR: assert property (
        !$stable(gain_select) |-> $past(sfr_wr) && $past(sfr_addr) == `ADDR_CONVERTER_CONFIG)
        else $error("gain moved");
    AST_CHAN_WR: assert property (
        !$stable(channel_select) |-> $past(sfr_wr) && $past(sfr_addr) == `ADDR_CHANNEL_SELECT)
        else $error("channel moved");
    cover property (conversion_irq);
    cover property ($rose(convert_active));
    cover property (track_enable && !convert_active && sar_clock_tick);
endmodule // sar_adc_sequencer_8bit_chk
bind sar_adc_sequencer_8bit sar_adc_sequencer_8bit_chk chk_i (.clk_sys, .resetn, .sfr_addr,
    .sfr_wr, .port_input_mode_reg, .irq_enable, .crossbar_skip, .converter_power_on,
    .track_enable, .convert_active, .sar_clock_tick, .gain_select, .channel_select,
    .conversion_irq);
`default_nettype wire

// File: testbench/sar_adc_sequencer_8bit_tb.sv
// Self-checking bench for the SAR sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_8bit_tb;
    logic clk_sys, resetn, sfr_wr, sfr_rd, timer3_overflow, timer2_overflow, primary_busy_write;
    logic ext_convert_start_a, ext_convert_start_b, ext_start_a_in_crossbar;
    logic ext_start_b_in_crossbar, irq_enable, converter_power_on, track_enable, convert_active;
    logic sar_clock_tick, channel_is_diff, conversion_irq;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, port_input_mode_reg, conv_result_in, crossbar_skip;
    logic [7:0] v, ctl;
    logic [7:0] q[$];
    logic [7:0] ra[6] = '{8'hBA, 8'hBB, 8'hBC, 8'hBE, 8'hE8, 8'hC0};
    logic [7:0] re[6] = '{8'h00, 8'h00, 8'hF8, 8'h00, 8'h00, 8'h00};
    logic [1:0] gain_select;
    logic [2:0] channel_select;
    int n_errors, checks, seed, i, k;
    sar_adc_sequencer_8bit dut (.clk_sys, .resetn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
        .sfr_rdata, .timer3_overflow, .timer2_overflow, .primary_busy_write, .ext_convert_start_a,
        .ext_convert_start_b, .ext_start_a_in_crossbar, .ext_start_b_in_crossbar,
        .port_input_mode_reg, .conv_result_in, .irq_enable, .crossbar_skip, .converter_power_on,
        .track_enable, .convert_active, .sar_clock_tick, .gain_select, .channel_select,
        .channel_is_diff, .conversion_irq);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // Bus, trigger and compare tasks
    // ----------------------------------------
    task chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1 chk(sfr_rdata, e);
    endtask
    task trig(input int kk, input logic lv);
        case (kk)
            0: begin
                sfr_addr <= 8'hE8;
                sfr_wdata <= ctl | 8'h10;
                sfr_wr <= lv;
            end
            1: timer3_overflow <= lv;
            2: if (ext_start_b_in_crossbar) ext_convert_start_b <= lv;
               else ext_convert_start_a <= lv;
            3: timer2_overflow <= lv;
            default: primary_busy_write <= lv;
        endcase
    endtask
    // Retrigger at cycle 60 lands mid-conversion: divider 13 keeps it there
    task conv(input int kk, input logic tm);
        int n, tk, tt, irqs, st, bad;
        tk = 0; tt = 0; irqs = 0; st = 0; bad = 0;
        ctl = {1'b1, tm, 2'b00, (kk > 3) ? 3'h4 : kk[2:0], 1'b0};
        @(posedge clk_sys);
        trig(kk, 1'b0);
        v = $random(seed);
        irq_enable <= v[0];
        v = $random(seed);
        conv_result_in <= v;
        q.push_back(v);
        wr(8'hE8, ctl);
        for (n = 0; n < 3000 && st < 3; n++) begin
            @(posedge clk_sys);
            trig(kk, (kk == 2) ? !(n >= 50 && n < 60) : (n == 0 || n == 60));
            #1;
            tk += sar_clock_tick && convert_active && !track_enable;
            // Busy covers only the convert phase; pin rises at n 0 but its synchronised level stays low until n 2
            tt += tm && sar_clock_tick && track_enable && !convert_active && (kk != 2 || n > 1);
            bad += !tm && (track_enable == convert_active);
            irqs += conversion_irq;
            if (st > 0 || (!convert_active && tk > 0)) st++;
        end
        if (st < 3) begin
            n_errors++;
            print_verdict;
        end
        chk(8'(tk), 8'h0C);
        chk(8'(tt), (tm && kk != 2) ? 8'h03 : 8'h00);
        chk(8'(bad), 8'h00);
        chk(8'(irqs), 8'(irq_enable));
        rd(8'hE8, ctl | 8'h20);
        rd(8'hBE, q.pop_front());
        wr(8'hE8, ctl);
    endtask
    task print_verdict;
        $display("n_errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 29; n_errors = 0; checks = 0; ctl = 8'h00;
        {resetn, sfr_wr, sfr_rd, timer3_overflow, timer2_overflow, primary_busy_write} = 6'h00;
        {ext_convert_start_a, ext_convert_start_b, ext_start_a_in_crossbar} = 3'h0;
        ext_start_b_in_crossbar = 1'b1;
        irq_enable = 1'b1;
        {sfr_addr, sfr_wdata, conv_result_in} = 24'h000000;
        port_input_mode_reg = 8'hFF;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        for (i = 0; i < 6; i++) rd(ra[i], re[i]);
        chk(8'(gain_select), 8'h00);
        wr(8'hBA, 8'hFF);
        rd(8'hBA, 8'h0F);
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            wr(8'hBA, v);
            wr(8'hBB, 8'(i));
            #1 chk(8'(channel_select), 8'(i));
            chk(8'(channel_is_diff), 8'(v[i / 2]));
        end
        // Mux settling after the last channel change
        repeat (80) @(posedge clk_sys);
        for (i = 0; i < 4; i++) begin
            wr(8'hBC, {5'h0D, 1'b1, 2'(i)});
            #1 chk(8'(gain_select), 8'(i));
            rd(8'hBC, {5'h0D, 1'b0, 2'(i)});
        end
        for (i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            v = $random(seed);
            port_input_mode_reg <= v;
            #1 chk(crossbar_skip, ~v);
        end
        wr(8'hE8, 8'h80);
        for (k = 0; k < 2; k++) begin
            wr(8'hBC, k ? 8'hF8 : 8'h68);
            for (i = 0; i < 99; i++) begin @(posedge clk_sys); #1 if (sar_clock_tick) break; end
            for (i = 1; i < 99; i++) begin @(posedge clk_sys); #1 if (sar_clock_tick) break; end
            chk(8'(i), k ? 8'h20 : 8'h0E);
        end
        wr(8'hBC, 8'h68);
        for (k = 0; k < 5; k++) begin
            ctl = (k == 0) ? 8'h02 : 8'h82;
            wr(8'hE8, ctl);
            #1 chk(8'(track_enable), 8'(k != 0));
            @(posedge clk_sys);
            trig(k == 0 ? 1 : k == 1 ? 0 : k, 1'b1);
            @(posedge clk_sys);
            trig(k == 0 ? 1 : k == 1 ? 0 : k, 1'b0);
            repeat (8) @(posedge clk_sys);
            #1 chk(8'(convert_active), 8'h00);
            chk(8'(converter_power_on), 8'(k != 0));
        end
        for (k = 0; k < 5; k++) conv(k, 1'b0);
        conv(1, 1'b1);
        conv(4, 1'b1);
        conv(2, 1'b1);
        ext_start_b_in_crossbar <= 1'b0;
        ext_start_a_in_crossbar <= 1'b1;
        conv(2, 1'b0);
        print_verdict;
    end
endmodule // sar_adc_sequencer_8bit_tb
`default_nettype wire
